// [hw/php_host_end.sv]
// host controller end: Avalon-MM slave that runs parallel port cycles
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module php_host_end
  import php_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  php_bus_if.host bus,
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest
);

  // ==========================================================
  // pin synchronisers
  logic [8:0] sync1_ff;
  logic [8:0] sync2_ff;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sync1_ff <= 9'h1FF;
      sync2_ff <= 9'h1FF;
    end
    else
    begin
      sync1_ff <= {bus.int_n, bus.data_bus};
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================
  // cycle sequencer
  typedef enum logic [4:0] {
    PHP_H_IDLE = 5'h01,
    PHP_H_SETUP = 5'h02,
    PHP_H_STROBE = 5'h04,
    PHP_H_HOLD = 5'h08,
    PHP_H_ANSWER = 5'h10
  } php_hstate_t;

  php_hstate_t state_ff;
  php_hstate_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic is_read_ff;
  logic nxt_is_read;
  logic [1:0] ctrl_ff;
  logic [1:0] nxt_ctrl;
  logic cs_n_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic ds_n_ff;
  logic rw_n_ff;
  logic [9:0] addr_ff;
  logic [7:0] hdat_ff;
  logic hoe_ff;
  logic [7:0] rdata_ff;
  logic wait_ff;
  logic nxt_cs_n;
  logic nxt_rd_n;
  logic nxt_wr_n;
  logic nxt_ds_n;
  logic nxt_rw_n;
  logic [9:0] nxt_addr;
  logic [7:0] nxt_hdat;
  logic nxt_hoe;
  logic [7:0] nxt_rdata;
  logic nxt_wait;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_is_read = is_read_ff;
    nxt_ctrl = ctrl_ff;
    nxt_cs_n = cs_n_ff;
    nxt_rd_n = rd_n_ff;
    nxt_wr_n = wr_n_ff;
    nxt_ds_n = ds_n_ff;
    nxt_rw_n = rw_n_ff;
    nxt_addr = addr_ff;
    nxt_hdat = hdat_ff;
    nxt_hoe = hoe_ff;
    nxt_rdata = rdata_ff;
    nxt_wait = 1'b1;
    unique case (state_ff)
      PHP_H_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          if (avs_address[PHP_AVS_LOCAL_BIT])
          begin
            if (avs_address[0] == PHP_AVS_CTRL)
            begin
              if (avs_write)
              begin
                nxt_ctrl = avs_writedata[1:0];
              end
              nxt_rdata = {6'h00, ctrl_ff};
            end
            else
            begin
              nxt_rdata = {7'h00, !sync2_ff[8]};
            end
            nxt_wait = 1'b0;
            nxt_state = PHP_H_ANSWER;
          end
          else
          begin
            // address and data on separate lines
            nxt_addr = avs_address[9:0];
            nxt_hdat = avs_writedata;
            nxt_hoe = avs_write;
            nxt_is_read = avs_read;
            nxt_rw_n = avs_read;
            nxt_cs_n = 1'b0;
            nxt_cnt = PHP_SETUP_CYC - 4'h1;
            nxt_state = PHP_H_SETUP;
          end
        end
      end
      PHP_H_SETUP:
      begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h0)
        begin
          if (ctrl_ff == PHP_STYLE_DSTRB)
          begin
            nxt_ds_n = 1'b0;
          end
          else
          begin
            nxt_rd_n = !is_read_ff;
            nxt_wr_n = is_read_ff;
          end
          nxt_cnt = PHP_STROBE_CYC - 4'h1;
          nxt_state = PHP_H_STROBE;
        end
      end
      PHP_H_STROBE:
      begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h0)
        begin
          nxt_rdata = sync2_ff[7:0];
          nxt_rd_n = 1'b1;
          nxt_wr_n = 1'b1;
          nxt_ds_n = 1'b1;
          nxt_cnt = PHP_HOLD_CYC - 4'h1;
          nxt_state = PHP_H_HOLD;
        end
      end
      PHP_H_HOLD:
      begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h0)
        begin
          nxt_cs_n = 1'b1;
          nxt_hoe = 1'b0;
          nxt_rw_n = 1'b1;
          nxt_wait = 1'b0;
          nxt_state = PHP_H_ANSWER;
        end
      end
      PHP_H_ANSWER:
      begin
        nxt_state = PHP_H_IDLE;
      end
      default:
      begin
        nxt_state = PHP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_ff <= PHP_H_IDLE;
      cnt_ff <= 4'h0;
      is_read_ff <= 1'b0;
      ctrl_ff <= PHP_HOST_CTRL_RST;
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      ds_n_ff <= 1'b1;
      rw_n_ff <= 1'b1;
      addr_ff <= 10'h000;
      hdat_ff <= 8'h00;
      hoe_ff <= 1'b0;
      rdata_ff <= 8'h00;
      wait_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      is_read_ff <= nxt_is_read;
      ctrl_ff <= nxt_ctrl;
      cs_n_ff <= nxt_cs_n;
      rd_n_ff <= nxt_rd_n;
      wr_n_ff <= nxt_wr_n;
      ds_n_ff <= nxt_ds_n;
      rw_n_ff <= nxt_rw_n;
      addr_ff <= nxt_addr;
      hdat_ff <= nxt_hdat;
      hoe_ff <= nxt_hoe;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
    end
  end

  // ==========================================================
  // outputs
  assign bus.bus_style_select = ctrl_ff;
  assign bus.cs_n = cs_n_ff;
  assign bus.rd_n = rd_n_ff;
  assign bus.wr_n = wr_n_ff;
  assign bus.data_strobe_n = ds_n_ff;
  assign bus.rw_n = rw_n_ff;
  assign bus.register_address_lines = addr_ff;
  assign bus.h_data_o = hdat_ff;
  assign bus.h_data_oe = hoe_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

endmodule // php_host_end

// [hw/php_pkg.sv]
// shared constants for both ends of the parallel host port
//
// Notes on behaviour
// - style pins: 00 split strobes, 01 data strobe
// - eight-bit data bus in both styles
// - ten dedicated address lines on every access
// - no multiplexed address and data
// - select low for access; strobes ignored otherwise
// - split style: read strobe reads, write strobe writes
// - data strobe: direction high reads, low writes
// - interrupt low while unmasked condition active; open-drain
// - reading latched status clears its bits
// - event during status read stays latched
// - software services all status bits together
// - drive-mode bit set drives inactive interrupt high
// - interrupt floats after reset until active
// - bus outputs float while reset held
package php_pkg;

  // ==========================================================
  // widths and styles
  localparam int PHP_DW = 8;
  localparam int PHP_AW = 10;
  localparam logic [1:0] PHP_STYLE_SPLIT = 2'h0;
  localparam logic [1:0] PHP_STYLE_DSTRB = 2'h1;
  localparam logic [7:0] PHP_BUS_IDLE = 8'hFF;

  // ==========================================================
  // device register map
  localparam logic [9:0] PHP_REG_CTRL = 10'h000;
  localparam logic [9:0] PHP_REG_STATUS = 10'h001;
  localparam logic [9:0] PHP_REG_MASK = 10'h002;
  localparam logic [9:0] PHP_REG_CFG = 10'h003;
  localparam int PHP_CTRL_DRIVE_BIT = 0;
  localparam logic [7:0] PHP_CTRL_RST = 8'h00;
  localparam logic [7:0] PHP_MASK_RST = 8'h00;
  localparam logic [7:0] PHP_CFG_RST = 8'h00;
  localparam logic [7:0] PHP_STATUS_RST = 8'h00;
  localparam logic [7:0] PHP_UNMAPPED_READ = 8'h00;

  // ==========================================================
  // host controller timing and local map
  localparam logic [3:0] PHP_SETUP_CYC = 4'h2;
  localparam logic [3:0] PHP_STROBE_CYC = 4'h8;
  localparam logic [3:0] PHP_HOLD_CYC = 4'h4;
  localparam int PHP_AVS_AW = 11;
  localparam int PHP_AVS_LOCAL_BIT = 10;
  localparam logic PHP_AVS_CTRL = 1'b0;
  localparam logic PHP_AVS_STAT = 1'b1;
  localparam logic [1:0] PHP_HOST_CTRL_RST = 2'h0;

endpackage

// [hw/php_bus_if.sv]
// pin-level carrier between host controller and device port
`timescale 1ns/1ps
interface php_bus_if;
  import php_pkg::*;

  logic [1:0] bus_style_select;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic data_strobe_n;
  logic rw_n;
  logic [9:0] register_address_lines;
  logic [7:0] h_data_o;
  logic h_data_oe;
  logic [7:0] d_data_o;
  logic d_data_oe;
  logic [7:0] data_bus;
  logic int_n_o;
  logic int_n_oe;
  logic int_n;

  // resolved wire levels; undriven lines sit pulled high
  assign data_bus = d_data_oe ? d_data_o : (h_data_oe ? h_data_o : PHP_BUS_IDLE);
  assign int_n = int_n_oe ? int_n_o : 1'b1;

  modport device (
    input bus_style_select, cs_n, rd_n, wr_n, data_strobe_n, rw_n,
    input register_address_lines, data_bus,
    output d_data_o, d_data_oe, int_n_o, int_n_oe
  );

  modport host (
    output bus_style_select, cs_n, rd_n, wr_n, data_strobe_n, rw_n,
    output register_address_lines, h_data_o, h_data_oe,
    input data_bus, int_n
  );

endinterface // php_bus_if

// [hw/php_device_end.sv]
// device end of the parallel host port with latched status and interrupt
`timescale 1ns/1ps
module php_device_end
  import php_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  php_bus_if.device bus,
  input wire logic [7:0] event_in,
  output logic [7:0] cfg_q,
  output logic [7:0] status_q
);

  // ==========================================================
  // pin synchronisers
  localparam logic [24:0] SYNC_RST = {2'h0, 5'h1F, 10'h000, 8'hFF};

  logic [24:0] pin_vec;
  logic [24:0] sync1_ff;
  logic [24:0] sync2_ff;

  assign pin_vec = {bus.bus_style_select, bus.cs_n, bus.rd_n, bus.wr_n,
                    bus.data_strobe_n, bus.rw_n, bus.register_address_lines,
                    bus.data_bus};

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end
    else
    begin
      sync1_ff <= pin_vec;
      sync2_ff <= sync1_ff;
    end
  end

  logic [1:0] style_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic ds_n_s;
  logic rw_n_s;
  logic [9:0] addr_s;
  logic [7:0] data_s;

  assign style_s = sync2_ff[24:23];
  assign cs_n_s = sync2_ff[22];
  assign rd_n_s = sync2_ff[21];
  assign wr_n_s = sync2_ff[20];
  assign ds_n_s = sync2_ff[19];
  assign rw_n_s = sync2_ff[18];
  assign addr_s = sync2_ff[17:8];
  assign data_s = sync2_ff[7:0];

  // ==========================================================
  // strobe decode
  logic rd_act;
  logic wr_act;

  always_comb
  begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (!cs_n_s)
    begin
      unique case (style_s)
        PHP_STYLE_SPLIT:
        begin
          rd_act = !rd_n_s;
          wr_act = !wr_n_s;
        end
        PHP_STYLE_DSTRB:
        begin
          rd_act = !ds_n_s && rw_n_s;
          wr_act = !ds_n_s && !rw_n_s;
        end
        default:
        begin
          rd_act = 1'b0;
          wr_act = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // access tracking and register file
  logic rd_q_ff;
  logic wr_q_ff;
  logic [9:0] acc_addr_ff;
  logic [7:0] wdat_ff;
  logic [7:0] rdval_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] mask_ff;
  logic [7:0] cfg_ff;
  logic [7:0] status_ff;
  logic nxt_rd_q;
  logic nxt_wr_q;
  logic [9:0] nxt_acc_addr;
  logic [7:0] nxt_wdat;
  logic [7:0] nxt_rdval;
  logic [7:0] nxt_ctrl;
  logic [7:0] nxt_mask;
  logic [7:0] nxt_cfg;
  logic [7:0] nxt_status;

  function automatic logic [7:0] read_mux(
    input logic [9:0] a,
    input logic [7:0] c,
    input logic [7:0] s,
    input logic [7:0] m,
    input logic [7:0] g
  );
    unique case (a)
      PHP_REG_CTRL: read_mux = c;
      PHP_REG_STATUS: read_mux = s;
      PHP_REG_MASK: read_mux = m;
      PHP_REG_CFG: read_mux = g;
      default: read_mux = PHP_UNMAPPED_READ;
    endcase
  endfunction

  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic [7:0] clr_bits;

  assign rd_start = rd_act && !rd_q_ff;
  assign rd_end = !rd_act && rd_q_ff;
  assign wr_end = !wr_act && wr_q_ff;

  always_comb
  begin
    nxt_rd_q = rd_act;
    nxt_wr_q = wr_act;
    nxt_acc_addr = acc_addr_ff;
    nxt_wdat = wdat_ff;
    nxt_rdval = rdval_ff;
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_cfg = cfg_ff;
    clr_bits = 8'h00;
    if (rd_act || wr_act)
    begin
      nxt_acc_addr = addr_s;
    end
    if (wr_act)
    begin
      nxt_wdat = data_s;
    end
    // value snapshot once per read pulse
    if (rd_start)
    begin
      nxt_rdval = read_mux(addr_s, ctrl_ff, status_ff, mask_ff, cfg_ff);
    end
    // only the bits that were shown are cleared
    if (rd_end && acc_addr_ff == PHP_REG_STATUS)
    begin
      clr_bits = rdval_ff;
    end
    // write commits at strobe release
    if (wr_end)
    begin
      unique case (acc_addr_ff)
        PHP_REG_CTRL: nxt_ctrl = wdat_ff;
        PHP_REG_MASK: nxt_mask = wdat_ff;
        PHP_REG_CFG: nxt_cfg = wdat_ff;
        default: nxt_cfg = cfg_ff;
      endcase
    end
    nxt_status = (status_ff & ~clr_bits) | event_in;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rd_q_ff <= 1'b0;
      wr_q_ff <= 1'b0;
      acc_addr_ff <= 10'h000;
      wdat_ff <= 8'h00;
      rdval_ff <= 8'h00;
      ctrl_ff <= PHP_CTRL_RST;
      mask_ff <= PHP_MASK_RST;
      cfg_ff <= PHP_CFG_RST;
      status_ff <= PHP_STATUS_RST;
    end
    else
    begin
      rd_q_ff <= nxt_rd_q;
      wr_q_ff <= nxt_wr_q;
      acc_addr_ff <= nxt_acc_addr;
      wdat_ff <= nxt_wdat;
      rdval_ff <= nxt_rdval;
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      cfg_ff <= nxt_cfg;
      status_ff <= nxt_status;
    end
  end

  // ==========================================================
  // interrupt pin
  logic int_o_ff;
  logic int_oe_ff;
  logic nxt_int_o;
  logic nxt_int_oe;
  logic pending;

  always_comb
  begin
    pending = |(status_ff & mask_ff);
    nxt_int_o = !pending;
    nxt_int_oe = pending || ctrl_ff[PHP_CTRL_DRIVE_BIT];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      int_o_ff <= 1'b1;
      int_oe_ff <= 1'b0;
    end
    else
    begin
      int_o_ff <= nxt_int_o;
      int_oe_ff <= nxt_int_oe;
    end
  end

  // ==========================================================
  // outputs
  assign bus.d_data_o = rdval_ff;
  assign bus.d_data_oe = rd_q_ff;
  assign bus.int_n_o = int_o_ff;
  assign bus.int_n_oe = int_oe_ff;
  assign cfg_q = cfg_ff;
  assign status_q = status_ff;

endmodule // php_device_end

// [bench/php_properties.sv]
// pin-level checks on the parallel host port between the two ends
`timescale 1ns/1ps
module php_properties
  import php_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] bus_style_select,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_strobe_n,
  input wire logic rw_n,
  input wire logic [9:0] register_address_lines,
  input wire logic h_data_oe,
  input wire logic d_data_oe,
  input wire logic int_n_o,
  input wire logic int_n_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // assertions
  property p_rst_float;
    $rose(reset_n) |-> !d_data_oe && !int_n_oe;
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("port drives after reset");
  property p_cs_idle;
    cs_n [*5] |-> !d_data_oe;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("data driven while deselected");
  property p_no_clash;
    !(d_data_oe && h_data_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  property p_style_pins;
    bus_style_select == PHP_STYLE_DSTRB |-> rd_n && wr_n;
  endproperty
  a_style_pins: assert property (p_style_pins) else $error("split strobe in data strobe style");
  property p_wr_pulse;
    $fell(wr_n) |-> (!wr_n && h_data_oe && !cs_n) [*8] ##1 wr_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe malformed");
  property p_ds_pulse;
    $fell(data_strobe_n) |-> ($stable(rw_n) && !data_strobe_n) [*8] ##1 data_strobe_n;
  endproperty
  a_ds_pulse: assert property (p_ds_pulse) else $error("data strobe malformed");
  property p_rd_answer;
    $fell(rd_n) && bus_style_select == PHP_STYLE_SPLIT |-> ##[2:4] d_data_oe;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_addr_hold;
    !wr_n && !$past(wr_n) |-> $stable(register_address_lines);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
  property p_int_od;
    !int_n_o |-> int_n_oe;
  endproperty
  a_int_od: assert property (p_int_od) else $error("interrupt low but released");
endmodule // php_properties

// [bench/tb.sv]
// self-checking bench joining host and device ends of the port
`timescale 1ns/1ps
module tb;
  import php_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [10:0] avs_address = 11'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] event_in = 8'h00;
  logic [7:0] cfg_q;
  logic [7:0] status_q;
  logic [7:0] rd_val;
  logic [7:0] cfg_exp;
  int err_total = 0;
  int checked = 0;

  php_bus_if bus ();
  always #12.5 clk_sys = ~clk_sys;

  php_host_end u_php_host_end (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  php_device_end u_php_device_end (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .event_in(event_in),
    .cfg_q(cfg_q), .status_q(status_q));
  php_properties u_php_properties (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus_style_select(bus.bus_style_select), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .data_strobe_n(bus.data_strobe_n), .rw_n(bus.rw_n), .register_address_lines(bus.register_address_lines),
    .h_data_oe(bus.h_data_oe), .d_data_oe(bus.d_data_oe), .int_n_o(bus.int_n_o), .int_n_oe(bus.int_n_oe));

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // avalon access: hold until waitrequest low, then release
  task automatic av(input logic wr, input logic [10:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40)
      chk("waitrequest", 8'h01, 8'h00);
    rd_val = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  function automatic logic [7:0] irq();
    return {6'h00, bus.int_n_oe, bus.int_n};
  endfunction

  // ==========================================================
  // tests
  initial
  begin
    repeat (10) @(posedge clk_sys);
    chk("reset data oe", {7'h00, bus.d_data_oe}, 8'h00);
    chk("reset irq", irq(), 8'h01);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    cfg_exp = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      av(1'b1, 11'h400, 8'(i));
      av(1'b0, 11'h400, 8'h00);
      chk("style", rd_val & 8'h03, 8'(i));
      if (i < 2)
        cfg_exp = 8'hA5 ^ 8'(i * 255);
      av(1'b1, 11'h003, 8'hA5 ^ 8'(i * 255));
      chk("cfg write", cfg_q, cfg_exp);
      av(1'b0, 11'h003, 8'h00);
      chk("cfg read", rd_val, (i < 2) ? cfg_exp : PHP_BUS_IDLE);
    end
    av(1'b1, 11'h400, 8'h00);
    av(1'b0, 11'h3FF, 8'h00);
    chk("unmapped read", rd_val, PHP_UNMAPPED_READ);
    av(1'b1, 11'h203, 8'h11);
    chk("alias write", cfg_q, cfg_exp);
    event_in <= 8'h01;
    @(posedge clk_sys);
    event_in <= 8'h00;
    repeat (3) @(posedge clk_sys);
    chk("status set", status_q, 8'h01);
    chk("masked irq", irq(), 8'h01);
    av(1'b1, 11'h002, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq low", irq(), 8'h02);
    av(1'b0, 11'h401, 8'h00);
    chk("irq pending", rd_val & 8'h01, 8'h01);
    fork
      av(1'b0, 11'h001, 8'h00);
      begin
        repeat (10) @(posedge clk_sys);
        event_in <= 8'h02;
        repeat (8) @(posedge clk_sys);
        event_in <= 8'h00;
      end
    join
    chk("status read", rd_val, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("event kept", status_q, 8'h02);
    chk("irq released", irq(), 8'h01);
    av(1'b1, 11'h000, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq driven high", irq(), 8'h03);
    av(1'b1, 11'h002, 8'h03);
    repeat (2) @(posedge clk_sys);
    chk("irq second", irq(), 8'h02);
    av(1'b0, 11'h001, 8'h00);
    chk("status all", rd_val, 8'h02);
    repeat (2) @(posedge clk_sys);
    chk("status cleared", status_q, 8'h00);
    chk("irq inactive", irq(), 8'h03);
    event_in <= 8'h01;
    @(posedge clk_sys);
    event_in <= 8'h00;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("reset outputs", {6'h00, bus.d_data_oe, bus.int_n_oe}, 8'h00);
    chk("reset status", status_q, PHP_STATUS_RST);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    conclude();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
endmodule // tb
